// ---- bench/core_model.sv ----
// Core sequencer model: instruction ends, call acknowledge and return
`timescale 1ns/1ns
module core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] ack_wait,
  input wire logic ret_cmd,
  input wire logic last_en,
  output logic instr_last,
  output logic irq_ack,
  output logic return_from_irq,
  output int ack_cnt,
  output logic [15:0] taken_vec
);
  logic pend;
  logic ph;
  logic [1:0] cnt;
  int depth;
  always_ff @(posedge mclk) begin
    if (rst) begin
      {pend, ph, cnt, instr_last, irq_ack, return_from_irq} <= '0;
      ack_cnt <= 0;
      depth <= 0;
      taken_vec <= '0;
    end else begin
      ph <= ~ph;
      instr_last <= last_en & ph;
      // call taken after a delay, nesting depth counted
      irq_ack <= 1'b0;
      if (!irq_req || irq_ack) begin
        pend <= 1'b0;
      end else if (!pend) begin
        pend <= 1'b1;
        cnt <= ack_wait;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else begin
        irq_ack <= 1'b1;
        taken_vec <= irq_vector;
        ack_cnt <= ack_cnt + 1;
        depth <= depth + 1;
        pend <= 1'b0;
      end
      return_from_irq <= ret_cmd && depth > 0;
      if (ret_cmd && depth > 0) begin
        depth <= depth - 1;
      end
    end
  end
endmodule

// ---- bench/two_level_interrupt_controller_tb.sv ----
// Self-checking bench of the two-level interrupt controller
`timescale 1ns/1ns
`include "irq_cfg.svh"
module two_level_interrupt_controller_tb;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ret_cmd = 1'b0, last_en = 1'b1;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, rdata, d;
  logic [15:0] ev = '0, irq_vector, taken_vec, en, pr;
  logic [1:0] ack_wait = '0, t2;
  logic irq_req, irq_high, instr_last, irq_ack, return_from_irq, ah = 1'b0, al = 1'b0;
  logic [6:0] f1, f2;
  logic [31:0] r;
  int errors = 0, n_compared = 0, cyc = 0, ack_cnt, seed = 46, w;
  int pos[15] = '{0, 5, 6, 1, 8, 12, 2, 9, 13, 3, 10, 14, 4, 11, 15};

  two_level_interrupt_controller #(.MC_DIV(1)) two_level_interrupt_controller_inst (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_in0(ev[0]), .t0_ovf_evt(ev[1]), .ext_in1(ev[2]), .t1_ovf_evt(ev[3]),
    .uart_evt(ev[4]), .bus_code_load(ev[5]), .conv_done_evt(ev[6]),
    .t2_wide_ovf_evt(ev[7]), .capture_evt(ev[11:8]), .compare_evt(ev[14:12]),
    .t2_byte_ovf_evt(ev[15]), .instr_last(instr_last), .irq_ack(irq_ack),
    .return_from_irq(return_from_irq), .irq_req(irq_req), .irq_high(irq_high),
    .irq_vector(irq_vector));
  core_model core_model_inst (
    .mclk(mclk), .rst(rst), .irq_req(irq_req), .irq_vector(irq_vector),
    .ack_wait(ack_wait), .ret_cmd(ret_cmd), .last_en(last_en), .instr_last(instr_last),
    .irq_ack(irq_ack), .return_from_irq(return_from_irq), .ack_cnt(ack_cnt),
    .taken_vec(taken_vec));

  // ==========================================================
  // Clock, timeout, verdict
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ==========================================================
  // Bus, event and core tasks
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask
  task automatic pulse(input logic [15:0] e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
  endtask
  task automatic ret();
    @(posedge mclk);
    ret_cmd <= 1'b1;
    @(posedge mclk);
    ret_cmd <= 1'b0;
    if (ah) ah = 1'b0;
    else al = 1'b0;
  endtask
  task automatic noreq(input int n);
    logic any;
    any = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      any = any | irq_req;
    end
    chk("no_request", any, 0);
  endtask
  task automatic serve(input int i, input logic hi);
    int n;
    for (int k = 0; k < 80 && irq_req !== 1'b1; k++) @(posedge mclk);
    chk("vector", irq_vector, `IRQ_VEC_BASE + `IRQ_VEC_STEP * i);
    chk("level", irq_high, hi);
    n = ack_cnt;
    for (int k = 0; k < 20 && ack_cnt == n; k++) @(posedge mclk);
    @(posedge mclk);
    chk("drop", irq_req, 0);
  endtask
  // Winner by level first, then polling order
  function automatic int pick(input logic [15:0] fl);
    int b;
    b = -1;
    for (int i = 14; i >= 0; i--)
      if (fl[pos[i]] && en[pos[i]] && en[7] && !ah && (!al || pr[pos[i]]) &&
          (b < 0 || pr[pos[i]] >= pr[pos[b]])) b = i;
    return b;
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 10; a++) begin
      rreg(a[3:0], d);
      chk("reset", d, 0);
    end
    for (int a = 0; a < 4; a++) begin
      r = $random(seed);
      wreg(a[3:0], r[7:0]);
      rreg(a[3:0], d);
      chk("rw", d, a == 2 ? r[7:0] & 8'h7F : r[7:0]);
      wreg(a[3:0], 8'h00);
    end
    wreg(4'h9, 8'hFF);
    rreg(4'h9, d);
    chk("unmapped", d, 0);
    wreg(`IRQ_OFS_FLAG_FIRST, 8'h40);
    rreg(`IRQ_OFS_FLAG_FIRST, d);
    chk("conv_sw_set", d, 0);
    wreg(`IRQ_OFS_CTRL, 8'h03);
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      r = $random(seed) & $random(seed);
      wreg(4'h4, r[7:0]);
      wreg(4'h5, r[15:8]);
      wreg(4'h6, {6'h0, r[17:16]});
      f1 = r[6:0] & 7'h3F;
      f2 = r[14:8];
      t2 = r[17:16];
      r = $random(seed) & $random(seed) & $random(seed);
      pulse(r[15:0]);
      f1 |= r[6:0];
      f2 |= r[14:8];
      t2 |= {r[7], r[15]};
      pr = $random(seed);
      en = $random(seed) | 16'h0080;
      wreg(4'h2, pr[7:0]);
      wreg(4'h3, pr[15:8]);
      wreg(4'h1, en[15:8]);
      wreg(4'h0, en[7:0]);
      w = pick({|t2, f2, 1'b0, f1});
      if (w < 0) noreq(20);
      else begin
        ack_wait <= r[17:16];
        serve(w, pr[pos[w]]);
        if (pr[pos[w]]) ah = 1'b1;
        else al = 1'b1;
        if (pos[w] < 4) f1[pos[w]] = 1'b0;
        rreg(4'h4, d);
        chk("flags_first", d, {1'b0, f1});
        rreg(4'h5, d);
        chk("flags_second", d, {|t2, f2});
        rreg(4'h6, d);
        chk("t2_ovf", d, {6'h0, t2});
        noreq(10);
      end
      wreg(4'h0, 8'h00);
      wreg(4'h4, 8'h00);
      wreg(4'h5, 8'h00);
      wreg(4'h6, 8'h00);
      en[7:0] = 8'h00;
      if (w >= 0) ret();
    end
    $display("test random polling done");
    wreg(4'h2, 8'h00);
    wreg(4'h3, 8'h01);
    wreg(4'h1, 8'h01);
    wreg(4'h0, 8'h82);
    pulse(16'h0002);
    serve(`IRQ_SRC_T0, 1'b0);
    wreg(4'h5, 8'h01);
    serve(4, 1'b1);
    pulse(16'h0002);
    noreq(12);
    wreg(4'h5, 8'h00);
    ret();
    noreq(12);
    ret();
    serve(`IRQ_SRC_T0, 1'b0);
    wreg(4'h0, 8'h00);
    ret();
    $display("test nesting done");
    wreg(4'h0, 8'h88);
    last_en <= 1'b0;
    wreg(4'h4, 8'h08);
    noreq(12);
    wreg(4'h4, 8'h00);
    last_en <= 1'b1;
    noreq(12);
    wreg(4'h4, 8'h08);
    serve(`IRQ_SRC_T1, 1'b0);
    rreg(4'h4, d);
    chk("t1_cleared", d, 0);
    wreg(4'h0, 8'h00);
    ret();
    $display("test blocking done");
    end_sim();
  end
endmodule

// ---- rtl/irq_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ==========================================================
// Register offsets
`define IRQ_OFS_EN_FIRST 4'h0
`define IRQ_OFS_EN_SECOND 4'h1
`define IRQ_OFS_PRI_FIRST 4'h2
`define IRQ_OFS_PRI_SECOND 4'h3
`define IRQ_OFS_FLAG_FIRST 4'h4
`define IRQ_OFS_FLAG_SECOND 4'h5
`define IRQ_OFS_T2_OVF 4'h6
`define IRQ_OFS_CTRL 4'h7
`define IRQ_REG_RESET 8'h00

// ==========================================================
// First register layout (enable, priority and flags)
`define IRQ_BIT_GATE 7
`define IRQ_BIT_CONV 6
`define IRQ_BIT_BUS 5
`define IRQ_BIT_UART 4
`define IRQ_BIT_T1 3
`define IRQ_BIT_EXT1 2
`define IRQ_BIT_T0 1
`define IRQ_BIT_EXT0 0

// ==========================================================
// Second register layout
`define IRQ_BIT_T2 7
`define IRQ_BIT_CMP 4
`define IRQ_BIT_CAP 0
`define IRQ_BIT_T2_BYTE 0
`define IRQ_BIT_T2_WIDE 1

// ==========================================================
// Control register layout
`define IRQ_BIT_EDGE0 0
`define IRQ_BIT_EDGE1 1
`define IRQ_BIT_ACT_LO 4
`define IRQ_BIT_ACT_HI 5
`define IRQ_BIT_REQ 6

// ==========================================================
// Polling order, first wins a tie
`define IRQ_SRC_EXT0 4'h0
`define IRQ_SRC_BUS 4'h1
`define IRQ_SRC_CONV 4'h2
`define IRQ_SRC_T0 4'h3
`define IRQ_SRC_EXT1 4'h6
`define IRQ_SRC_T1 4'h9

// ==========================================================
// Timing and vectors
`define IRQ_MC_DIV 6
`define IRQ_HOLD_INSTR 2'h2
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STEP 16'h0008

`endif

// ---- rtl/irq_pkg.sv ----
// Types of the interrupt controller
package irq_pkg;

  typedef enum logic [0:0] {
    REQ_IDLE = 1'b0,
    REQ_CALL = 1'b1
  } req_state_t;

  typedef struct packed {
    logic [7:0] en_first;
    logic [7:0] en_second;
    logic [7:0] pri_first;
    logic [7:0] pri_second;
    logic [6:0] flg_first;
    logic [3:0] flg_cap;
    logic [2:0] flg_cmp;
    logic [1:0] flg_t2;
    logic [1:0] ext_edge;
    logic [1:0] ext_prev;
    logic [14:0] sample;
    logic act_hi;
    logic act_lo;
    logic [1:0] hold;
    req_state_t req_st;
    logic [3:0] req_idx;
    logic req_high;
    logic [15:0] vector;
    logic [7:0] rdata;
    logic [7:0] div_cnt;
  } ctl_state_t;

endpackage

// ---- rtl/two_level_interrupt_controller.sv ----
// Two-level fifteen-source interrupt controller facing the core sequencer
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "irq_cfg.svh"

module two_level_interrupt_controller
  import irq_pkg::*;
#(
  parameter int NUM_SOURCES = 15,
  parameter int MC_DIV = `IRQ_MC_DIV
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ext_in0,
  input wire logic ext_in1,
  input wire logic t0_ovf_evt,
  input wire logic t1_ovf_evt,
  input wire logic uart_evt,
  input wire logic bus_code_load,
  input wire logic conv_done_evt,
  input wire logic [3:0] capture_evt,
  input wire logic [2:0] compare_evt,
  input wire logic t2_byte_ovf_evt,
  input wire logic t2_wide_ovf_evt,
  input wire logic instr_last,
  input wire logic irq_ack,
  input wire logic return_from_irq,
  output logic irq_req,
  output logic irq_high,
  output logic [15:0] irq_vector
);

  // ==========================================================
  // Elaboration checks
  // fifteen sources only
  if (NUM_SOURCES != 15) begin : g_bad_sources
    $error("Source count must be fifteen");
  end
  if (MC_DIV < 1 || MC_DIV > 256) begin : g_bad_div
    $error("Machine cycle divider out of range");
  end

  localparam logic [7:0] DIV_LAST = 8'(MC_DIV - 1);

  // ==========================================================
  // Helpers
  // bit layout of both registers in polling order
  function automatic logic [14:0] poll_order(input logic [6:0] a, input logic [7:0] b);
    poll_order = {b[`IRQ_BIT_T2], b[`IRQ_BIT_CAP + 3], a[`IRQ_BIT_UART],
                  b[`IRQ_BIT_CMP + 2], b[`IRQ_BIT_CAP + 2], a[`IRQ_BIT_T1],
                  b[`IRQ_BIT_CMP + 1], b[`IRQ_BIT_CAP + 1], a[`IRQ_BIT_EXT1],
                  b[`IRQ_BIT_CMP], b[`IRQ_BIT_CAP], a[`IRQ_BIT_T0],
                  a[`IRQ_BIT_CONV], a[`IRQ_BIT_BUS], a[`IRQ_BIT_EXT0]};
  endfunction

  function automatic logic [4:0] first_set(input logic [14:0] v);
    first_set = 5'h00;
    for (int i = 14; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 4'(i)};
      end
    end
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = 16'(`IRQ_VEC_BASE + 16'({12'h000, idx}) * `IRQ_VEC_STEP);
  endfunction

  // ==========================================================
  // State
  ctl_state_t s_reg;
  ctl_state_t s_next;

  logic tick;
  logic [7:0] flag_second;
  logic [14:0] pend_now;
  logic [14:0] pri_src;
  logic [14:0] elig_hi;
  logic [14:0] elig_lo;
  logic [4:0] win_hi;
  logic [4:0] win_lo;
  logic [7:0] ctrl_rd;
  logic blk_now;

  assign rdata = s_reg.rdata;
  assign irq_req = (s_reg.req_st == REQ_CALL);
  assign irq_high = s_reg.req_high;
  assign irq_vector = s_reg.vector;

  always_comb begin
    s_next = s_reg;
    tick = (s_reg.div_cnt == 8'h00);
    // both overflow flags share one request
    flag_second = {|s_reg.flg_t2, s_reg.flg_cmp, s_reg.flg_cap};
    // mask bits and global gate on the sample path
    pend_now = s_reg.en_first[`IRQ_BIT_GATE]
             ? (poll_order(s_reg.flg_first, flag_second)
                & poll_order(s_reg.en_first[6:0], s_reg.en_second))
             : 15'h0000;
    pri_src = poll_order(s_reg.pri_first[6:0], s_reg.pri_second);
    // levels already in service block equal or lower
    elig_hi = s_reg.act_hi ? 15'h0000 : (s_reg.sample & pri_src);
    elig_lo = (s_reg.act_hi || s_reg.act_lo) ? 15'h0000 : (s_reg.sample & ~pri_src);
    win_hi = first_set(elig_hi);
    win_lo = first_set(elig_lo);
    blk_now = return_from_irq || ((wr || rd) && addr <= `IRQ_OFS_PRI_SECOND);
    ctrl_rd = 8'h00;
    ctrl_rd[`IRQ_BIT_EDGE1:`IRQ_BIT_EDGE0] = s_reg.ext_edge;
    ctrl_rd[`IRQ_BIT_ACT_LO] = s_reg.act_lo;
    ctrl_rd[`IRQ_BIT_ACT_HI] = s_reg.act_hi;
    ctrl_rd[`IRQ_BIT_REQ] = (s_reg.req_st == REQ_CALL);

    // Machine cycle divider
    s_next.div_cnt = tick ? DIV_LAST : 8'(s_reg.div_cnt - 8'h01);

    // ========================================================
    // Register read, data only in the following cycle
    s_next.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `IRQ_OFS_EN_FIRST: s_next.rdata = s_reg.en_first;
        `IRQ_OFS_EN_SECOND: s_next.rdata = s_reg.en_second;
        `IRQ_OFS_PRI_FIRST: s_next.rdata = {1'b0, s_reg.pri_first[6:0]};
        `IRQ_OFS_PRI_SECOND: s_next.rdata = s_reg.pri_second;
        `IRQ_OFS_FLAG_FIRST: s_next.rdata = {1'b0, s_reg.flg_first};
        `IRQ_OFS_FLAG_SECOND: s_next.rdata = flag_second;
        `IRQ_OFS_T2_OVF: s_next.rdata = {6'h00, s_reg.flg_t2};
        `IRQ_OFS_CTRL: s_next.rdata = ctrl_rd;
        default: s_next.rdata = 8'h00;
      endcase
    end

    // ========================================================
    // Register write
    if (wr) begin
      unique case (addr)
        `IRQ_OFS_EN_FIRST: s_next.en_first = wdata;
        `IRQ_OFS_EN_SECOND: s_next.en_second = wdata;
        `IRQ_OFS_PRI_FIRST: s_next.pri_first = {1'b0, wdata[6:0]};
        `IRQ_OFS_PRI_SECOND: s_next.pri_second = wdata;
        `IRQ_OFS_FLAG_FIRST: begin
          // software sets and clears, converter flag clear only
          s_next.flg_first[5:0] = wdata[5:0];
          s_next.flg_first[`IRQ_BIT_CONV] = s_reg.flg_first[`IRQ_BIT_CONV]
                                            & wdata[`IRQ_BIT_CONV];
        end
        `IRQ_OFS_FLAG_SECOND: begin
          s_next.flg_cmp = wdata[`IRQ_BIT_CMP + 2:`IRQ_BIT_CMP];
          s_next.flg_cap = wdata[`IRQ_BIT_CAP + 3:`IRQ_BIT_CAP];
        end
        `IRQ_OFS_T2_OVF: s_next.flg_t2 = wdata[1:0];
        `IRQ_OFS_CTRL: s_next.ext_edge = wdata[`IRQ_BIT_EDGE1:`IRQ_BIT_EDGE0];
        default: begin
        end
      endcase
    end

    // ========================================================
    // Acknowledge and return from the core
    // acknowledge taken only while a call is offered
    if (irq_ack && s_reg.req_st == REQ_CALL) begin
      s_next.req_st = REQ_IDLE;
      if (s_reg.req_high) begin
        s_next.act_hi = 1'b1;
      end else begin
        s_next.act_lo = 1'b1;
      end
      if (s_reg.req_idx == `IRQ_SRC_T0) begin
        s_next.flg_first[`IRQ_BIT_T0] = 1'b0;
      end
      if (s_reg.req_idx == `IRQ_SRC_T1) begin
        s_next.flg_first[`IRQ_BIT_T1] = 1'b0;
      end
      if (s_reg.req_idx == `IRQ_SRC_EXT0 && s_reg.ext_edge[0]) begin
        s_next.flg_first[`IRQ_BIT_EXT0] = 1'b0;
      end
      if (s_reg.req_idx == `IRQ_SRC_EXT1 && s_reg.ext_edge[1]) begin
        s_next.flg_first[`IRQ_BIT_EXT1] = 1'b0;
      end
    end
    // return releases the innermost active level
    if (return_from_irq) begin
      if (s_reg.act_hi) begin
        s_next.act_hi = 1'b0;
      end else begin
        s_next.act_lo = 1'b0;
      end
    end

    // ========================================================
    // Hardware flag sets, winning over any clear in the same cycle
    s_next.ext_prev = {ext_in1, ext_in0};
    s_next.flg_first[`IRQ_BIT_EXT0] = s_reg.ext_edge[0]
      ? (s_next.flg_first[`IRQ_BIT_EXT0] | (ext_in0 & ~s_reg.ext_prev[0])) : ext_in0;
    s_next.flg_first[`IRQ_BIT_EXT1] = s_reg.ext_edge[1]
      ? (s_next.flg_first[`IRQ_BIT_EXT1] | (ext_in1 & ~s_reg.ext_prev[1])) : ext_in1;
    s_next.flg_first[`IRQ_BIT_T0] = s_next.flg_first[`IRQ_BIT_T0] | t0_ovf_evt;
    s_next.flg_first[`IRQ_BIT_T1] = s_next.flg_first[`IRQ_BIT_T1] | t1_ovf_evt;
    s_next.flg_first[`IRQ_BIT_UART] = s_next.flg_first[`IRQ_BIT_UART] | uart_evt;
    // status code load raises the bus port flag
    s_next.flg_first[`IRQ_BIT_BUS] = s_next.flg_first[`IRQ_BIT_BUS] | bus_code_load;
    s_next.flg_first[`IRQ_BIT_CONV] = s_next.flg_first[`IRQ_BIT_CONV] | conv_done_evt;
    // timer two flags only ever set here
    s_next.flg_cap = s_next.flg_cap | capture_evt;
    s_next.flg_cmp = s_next.flg_cmp | compare_evt;
    s_next.flg_t2[`IRQ_BIT_T2_BYTE] = s_next.flg_t2[`IRQ_BIT_T2_BYTE] | t2_byte_ovf_evt;
    s_next.flg_t2[`IRQ_BIT_T2_WIDE] = s_next.flg_t2[`IRQ_BIT_T2_WIDE] | t2_wide_ovf_evt;

    // ========================================================
    // Sample and poll once per machine cycle
    if (tick) begin
      // sample now, poll this sample next machine cycle
      s_next.sample = pend_now;
      if (instr_last && s_reg.hold != 2'h0) begin
        s_next.hold = 2'(s_reg.hold - 2'h1);
      end
      // Off instruction ends a raised call stands for the core
      if (!irq_ack && instr_last) begin
        // decided afresh each poll, nothing is kept
        if (s_reg.hold != 2'h0 || blk_now || !(win_hi[4] || win_lo[4])) begin
          s_next.req_st = REQ_IDLE;
        end else begin
          s_next.req_st = REQ_CALL;
          s_next.req_high = win_hi[4];
          s_next.req_idx = win_hi[4] ? win_hi[3:0] : win_lo[3:0];
          s_next.vector = vec_of(win_hi[4] ? win_hi[3:0] : win_lo[3:0]);
        end
      end
    end

    // holdoff after return or enable/priority access
    if (blk_now) begin
      s_next.hold = `IRQ_HOLD_INSTR;
    end
  end

  always_ff @(posedge mclk) begin
    // all masked and low after reset
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_ack_taken;
    irq_ack && irq_req;
  endsequence

  sequence s_call_raised;
    $rose(irq_req);
  endsequence

  a_reset_masks_all: assert property (
    @(posedge mclk) disable iff (1'b0)
    rst |=> (s_reg.en_first == 8'h00 && s_reg.pri_second == 8'h00 && !irq_req))
    else $error("Masks not cleared by reset");

  a_ack_drops_call: assert property (s_ack_taken |=> !irq_req)
    else $error("Call still offered after acknowledge");

  a_high_not_preempted: assert property (
    s_call_raised |-> !$past(s_reg.act_hi))
    else $error("Call raised during high service");

  a_low_same_level: assert property (
    s_call_raised ##0 !irq_high |-> !$past(s_reg.act_lo))
    else $error("Low call raised during low service");

  a_gate_needed: assert property (
    s_call_raised |-> $past(s_reg.en_first[`IRQ_BIT_GATE], 2))
    else $error("Call without global gate");

  a_poll_on_cycle: assert property (
    s_call_raised |-> $past(tick) && $past(instr_last))
    else $error("Call raised off the machine cycle");

  a_holdoff_kept: assert property (
    return_from_irq |=> !$rose(irq_req) [*3])
    else $error("Call during holdoff");

  a_timer0_cleared: assert property (
    s_ack_taken ##0 (s_reg.req_idx == `IRQ_SRC_T0) && !t0_ovf_evt && !wr
    |=> !s_reg.flg_first[`IRQ_BIT_T0])
    else $error("Timer zero flag kept after acknowledge");

  a_t2_flag_sticky: assert property (
    s_reg.flg_t2[`IRQ_BIT_T2_WIDE] && !(wr && addr == `IRQ_OFS_T2_OVF)
    |=> s_reg.flg_t2[`IRQ_BIT_T2_WIDE])
    else $error("Timer two flag cleared by hardware");

  a_conv_no_sw_set: assert property (
    wr && addr == `IRQ_OFS_FLAG_FIRST && !s_reg.flg_first[`IRQ_BIT_CONV] && !conv_done_evt
    |=> !s_reg.flg_first[`IRQ_BIT_CONV])
    else $error("Converter flag set by software");

  a_bus_flag_set: assert property (
    bus_code_load |=> s_reg.flg_first[`IRQ_BIT_BUS])
    else $error("Bus port flag missed");

  a_ext0_vector: assert property (
    irq_req && s_reg.req_idx == `IRQ_SRC_EXT0 |-> irq_vector == `IRQ_VEC_BASE)
    else $error("Wrong external zero vector");

  a_return_release: assert property (
    return_from_irq && s_reg.act_hi |=> !s_reg.act_hi && s_reg.act_lo == $past(s_reg.act_lo))
    else $error("Return did not release high level");

  a_high_first: assert property (
    s_call_raised ##0 !irq_high
    |-> $past(s_reg.act_hi || (s_reg.sample & pri_src) == 15'h0000))
    else $error("Low call chosen over a high one");

  a_ext1_cleared: assert property (
    s_ack_taken ##0 (s_reg.req_idx == `IRQ_SRC_EXT1) && s_reg.ext_edge[1] && !ext_in1 && !wr
    |=> !s_reg.flg_first[`IRQ_BIT_EXT1])
    else $error("Edge external flag kept after acknowledge");

  a_conv_sticky: assert property (
    s_reg.flg_first[`IRQ_BIT_CONV] && !(wr && addr == `IRQ_OFS_FLAG_FIRST)
    |=> s_reg.flg_first[`IRQ_BIT_CONV])
    else $error("Converter flag cleared by hardware");

  a_gate_off_quiet: assert property (
    tick && !s_reg.en_first[`IRQ_BIT_GATE] |=> s_reg.sample == 15'h0000)
    else $error("Source sampled with global gate off");

  a_t2_mask_off: assert property (
    tick && !s_reg.en_second[`IRQ_BIT_T2] |=> !s_reg.sample[14])
    else $error("Timer two sampled while masked");

  a_t2_or_request: assert property (
    tick && s_reg.en_first[`IRQ_BIT_GATE] && s_reg.en_second[`IRQ_BIT_T2] && (|s_reg.flg_t2)
    |=> s_reg.sample[14])
    else $error("Timer two overflow request missed");

  a_no_mid_instr: assert property (
    !instr_last && !irq_req |=> !irq_req)
    else $error("Call raised before instruction end");

  a_hold_after_access: assert property (
    wr && addr <= `IRQ_OFS_PRI_SECOND |=> !$rose(irq_req) [*3])
    else $error("Call right after mask access");

endmodule
